// ---- design/spi_register_map.sv ----
// Serial register map with status summary, mode-driven rewrites and banked wake configuration.
//
// How it works
// (R1) Summary bit sets when any represented bit sets
// (R2) Summary bit clears only when all clear
// (R3) Bit 0 supplies OR, bit 4 bus OR
// (R4) Bits 1-3,5-7 follow their status registers
// (R5) Wake level register excluded from summary
// (R6) Frame bit 7 selects write/clear or read
// (R7) Addresses 01 to 3f are read/write control
// (R8) Written value visible from next frame only
// (R9) Pair 3a/3b read-only, writes ignored
// (R10) Addresses 40 to 7e are status registers
// (R11) Access bit one clears status after returning
// (R12) Wake level shows live pins, never cleared
// (R13) Mode field follows mode actually in effect
// (R14) Sleep entry turns CAN on into wake
// (R15) Fail output stays asserted into sleep
// (R16) Configure in normal; stop allows few writes
// (R17) Banked accesses go to selected channel
// (R18) Banked register touches selected copy only
// (R19) Selective wake status not banked
// (R20) Address bits 6-0, access 7, data 15-8
// (R21) Summary field sent in every response
// (R22) Frames ignored in restart, sleep, fail-safe
// (R23) Status read without clear changes nothing
// (R24) Summary refreshed right before each response
`timescale 1ns/1ps

module spi_register_map
    import basis_device_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic spi_csn_b,
    input wire logic spi_clk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic [2:0] mode_now,
    input wire logic [7:0] stat_event [STAT_N],
    input wire logic [7:0] wake_pin_level,
    input wire logic [7:0] osc_config_a,
    input wire logic [7:0] osc_config_b,
    input wire logic fail_trigger,
    input wire logic fail_release,
    output logic fail_output,
    output logic [7:0] status_summary,
    output logic [7:0] mode_select_control,
    output logic [7:0] watchdog_control,
    output logic [7:0] first_bus_control,
    output logic [7:0] second_bus_group_control,
    output logic [7:0] fourth_bus_control
);

    // Pin synchronisers: csn, clk, sdi, then the eight wake pins
    logic [10:0] sync1_ff;
    logic [10:0] sync2_ff;
    logic csn_s;
    logic clk_s;
    logic sdi_s;
    logic [7:0] lvl_s;
    logic csn_prev_ff;
    logic clk_prev_ff;
    logic csn_fall;
    logic csn_rise;
    logic clk_rise;
    logic clk_fall;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sync1_ff <= 11'h001;
            sync2_ff <= 11'h001;
        end else begin
            sync1_ff <= {wake_pin_level, spi_sdi, spi_clk, spi_csn_b};
            sync2_ff <= sync1_ff;
        end
    end

    assign csn_s = sync2_ff[0];
    assign clk_s = sync2_ff[1];
    assign sdi_s = sync2_ff[2];
    assign lvl_s = sync2_ff[10:3];

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            csn_prev_ff <= 1'b1;
            clk_prev_ff <= 1'b0;
        end else begin
            csn_prev_ff <= csn_s;
            clk_prev_ff <= clk_s;
        end
    end

    assign csn_fall = csn_prev_ff && !csn_s;
    assign csn_rise = !csn_prev_ff && csn_s;
    assign clk_rise = !clk_prev_ff && clk_s;
    assign clk_fall = clk_prev_ff && !clk_s;

    // Frame shifter, least significant bit first
    frame_state_t state_ff;
    logic [4:0] cnt_ff;
    logic [15:0] rx_ff;
    logic [15:0] tx_ff;
    logic [7:0] summary_live;
    logic [7:0] read_byte;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_ff <= FRAME_IDLE;
            cnt_ff <= 5'h00;
            rx_ff <= 16'h0000;
            tx_ff <= 16'h0000;
        end else if (csn_fall) begin
            state_ff <= FRAME_SHIFT;
            cnt_ff <= 5'h00;
            tx_ff <= {RESET_BYTE, summary_live}; // (R21) (R24)
        end else if (csn_rise) begin
            state_ff <= FRAME_IDLE;
        end else if (state_ff == FRAME_SHIFT) begin
            if (clk_rise) begin
                rx_ff <= {sdi_s, rx_ff[15:1]};
                if (cnt_ff != FRAME_CNT_MAX) begin
                    cnt_ff <= cnt_ff + 5'h01;
                end
            end
            if (clk_fall) begin
                // Address byte is complete here, so the data byte answers in the same frame
                if (cnt_ff == FRAME_HALF) begin
                    tx_ff <= {RESET_BYTE, read_byte}; // (R20)
                end else begin
                    tx_ff <= {1'b0, tx_ff[15:1]};
                end
            end
        end
    end

    assign spi_sdo = tx_ff[0];
    assign spi_sdo_oe = (state_ff == FRAME_SHIFT);

    // Completed frame; a miscounted frame is dropped
    logic exec;
    logic [6:0] f_addr;
    logic f_acc;
    logic [7:0] f_data;
    logic interp;
    logic in_ctrl;
    logic in_bank;
    logic in_osc;
    logic wr_ok;

    assign exec = csn_rise && (state_ff == FRAME_SHIFT) && (cnt_ff == FRAME_LEN);
    assign f_addr = rx_ff[6:0]; // (R20)
    assign f_acc = rx_ff[7]; // (R6)
    assign f_data = rx_ff[15:8];
    assign interp = (mode_now == MODE_INIT) || (mode_now == MODE_NORMAL) || (mode_now == MODE_STOP); // (R22)
    assign in_ctrl = (f_addr >= A_CTRL_FIRST) && (f_addr <= A_CTRL_LAST); // (R7)
    assign in_bank = (f_addr >= A_BANK_FIRST) && (f_addr <= A_BANK_LAST);
    assign in_osc = (f_addr[6:1] == A_OSC_PAIR); // (R9)
    // Stop mode accepts only mode changes and watchdog service
    assign wr_ok = interp && in_ctrl && !in_osc && f_acc &&
                   ((mode_now != MODE_STOP) || (f_addr == A_MODE_SELECT) || (f_addr == A_WATCHDOG)); // (R16)

    // Control and banked storage
    logic [7:0] ctrl_ff [64];
    logic [7:0] swk_ff [4][32];
    logic [2:0] mode_prev_ff;
    logic [1:0] bank_sel;
    logic mode_change;
    logic enter_sleep;

    assign bank_sel = fourth_bus_control[BANK_LSB +: 2];
    assign mode_change = (mode_now != mode_prev_ff);
    assign enter_sleep = mode_change && (mode_now == MODE_SLEEP);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mode_prev_ff <= MODE_INIT;
        end else begin
            mode_prev_ff <= mode_now;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int i = 0; i < 64; i++) begin
                ctrl_ff[i] <= RESET_BYTE;
            end
            for (int b = 0; b < 4; b++) begin
                for (int k = 0; k < 32; k++) begin
                    swk_ff[b][k] <= RESET_BYTE;
                end
            end
        end else begin
            if (exec && wr_ok) begin
                if (in_bank) begin
                    swk_ff[bank_sel][f_addr[4:0]] <= f_data; // (R17) (R18)
                end else begin
                    ctrl_ff[f_addr[5:0]] <= f_data; // (R7) (R8)
                end
            end
            // Hardware rewrites come after the host write so the effective mode wins
            if (mode_change) begin
                ctrl_ff[A_MODE_SELECT[5:0]][MODE_LSB +: 2] <= mode_field(mode_now); // (R13)
            end
            if (enter_sleep) begin
                if (ctrl_ff[A_FIRST_BUS[5:0]][1:0] == CAN_ON) begin
                    ctrl_ff[A_FIRST_BUS[5:0]][1:0] <= CAN_WAKE; // (R14)
                end
                for (int j = 0; j < CAN_FIELDS; j++) begin
                    if (ctrl_ff[A_SECOND_BUS[5:0]][2*j +: 2] == CAN_ON) begin
                        ctrl_ff[A_SECOND_BUS[5:0]][2*j +: 2] <= CAN_WAKE; // (R14)
                    end
                end
            end
        end
    end

    assign mode_select_control = ctrl_ff[A_MODE_SELECT[5:0]];
    assign watchdog_control = ctrl_ff[A_WATCHDOG[5:0]];
    assign first_bus_control = ctrl_ff[A_FIRST_BUS[5:0]];
    assign second_bus_group_control = ctrl_ff[A_SECOND_BUS[5:0]];
    assign fourth_bus_control = ctrl_ff[A_FOURTH_BUS[5:0]];

    // Status registers; a new event beats a clear in the same cycle
    logic [7:0] stat_ff [STAT_N];

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int i = 0; i < STAT_N; i++) begin
                stat_ff[i] <= RESET_BYTE;
            end
        end else begin
            for (int i = 0; i < STAT_N; i++) begin
                if (exec && interp && f_acc && (f_addr == STAT_ADDR[i])) begin
                    stat_ff[i] <= stat_event[i]; // (R10) (R11)
                end else begin
                    stat_ff[i] <= stat_ff[i] | stat_event[i]; // (R23)
                end
            end
        end
    end

    // Summary; the wake level register has no term here
    assign summary_live[0] = |(stat_ff[SI_SUP0] | stat_ff[SI_SUP1]); // (R3) (R5)
    assign summary_live[1] = |stat_ff[SI_THERMAL]; // (R1) (R2) (R4)
    assign summary_live[2] = |stat_ff[SI_DEVICE]; // (R4)
    assign summary_live[3] = |stat_ff[SI_BUS0]; // (R4)
    assign summary_live[4] = |(stat_ff[SI_BUS2] | stat_ff[SI_BUS3]); // (R3)
    assign summary_live[5] = |stat_ff[SI_WAKE0]; // (R4)
    assign summary_live[6] = |stat_ff[SI_WAKE2]; // (R4)
    assign summary_live[7] = |stat_ff[SI_SMPS]; // (R4)

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            status_summary <= RESET_BYTE;
        end else begin
            status_summary <= summary_live;
        end
    end

    // Read data for the address held in the upper half of the shifter
    logic [6:0] r_addr;
    assign r_addr = rx_ff[14:8];

    always_comb begin
        read_byte = RESET_BYTE;
        if (r_addr[6:1] == A_OSC_PAIR) begin
            read_byte = r_addr[0] ? osc_config_b : osc_config_a; // (R9)
        end else if ((r_addr >= A_BANK_FIRST) && (r_addr <= A_BANK_LAST)) begin
            read_byte = swk_ff[bank_sel][r_addr[4:0]]; // (R18)
        end else if ((r_addr >= A_CTRL_FIRST) && (r_addr <= A_CTRL_LAST)) begin
            read_byte = ctrl_ff[r_addr[5:0]]; // (R8)
        end else if (r_addr == A_WAKE_LEVEL) begin
            read_byte = lvl_s; // (R12)
        end else begin
            for (int i = 0; i < STAT_N; i++) begin
                if (r_addr == STAT_ADDR[i]) begin
                    read_byte = stat_ff[i]; // (R19)
                end
            end
        end
    end

    // Fail output; release is not honoured while asleep
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            fail_output <= 1'b0;
        end else if (fail_trigger) begin
            fail_output <= 1'b1;
        end else if (fail_release && (mode_now != MODE_SLEEP)) begin
            fail_output <= 1'b0; // (R15)
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    property p_summary_set;
        (stat_event[SI_THERMAL] != 8'h00) |=> summary_live[1];
    endproperty
    a_summary_set: assert property (p_summary_set) else $error("thermal event did not set summary"); // (R1)

    // Checked on the registered output, so the output flop is covered too
    property p_summary_fall;
        $fell(status_summary[2]) |-> ($past(stat_ff[SI_DEVICE]) == 8'h00);
    endproperty
    a_summary_fall: assert property (p_summary_fall) else $error("summary cleared with device bits set"); // (R2)

    property p_summary_or;
        status_summary[4] == (($past(stat_ff[SI_BUS2]) != 8'h00) || ($past(stat_ff[SI_BUS3]) != 8'h00));
    endproperty
    a_summary_or: assert property (p_summary_or) else $error("bus summary is not the OR"); // (R3)

    property p_summary_out;
        (stat_event[SI_SMPS] != 8'h00) |=> ##1 status_summary[7];
    endproperty
    a_summary_out: assert property (p_summary_out) else $error("regulator summary output missing"); // (R4)

    property p_write_later;
        (exec && wr_ok && (f_addr == A_WATCHDOG)) |-> $stable(watchdog_control) ##1 (watchdog_control == $past(f_data));
    endproperty
    a_write_later: assert property (p_write_later) else $error("watchdog write not taken next cycle"); // (R8)

    property p_clear;
        (exec && interp && f_acc && (f_addr == STAT_ADDR[SI_THERMAL]) && (stat_event[SI_THERMAL] == 8'h00))
            |=> (stat_ff[SI_THERMAL] == 8'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("thermal status not cleared"); // (R11)

    property p_read_keeps;
        (exec && !f_acc && (f_addr == STAT_ADDR[SI_DEVICE]))
            |=> (stat_ff[SI_DEVICE] == ($past(stat_ff[SI_DEVICE]) | $past(stat_event[SI_DEVICE])));
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("plain read changed status"); // (R23)

    property p_mode_field;
        mode_change |=> (mode_select_control[7:6] == mode_field($past(mode_now)));
    endproperty
    a_mode_field: assert property (p_mode_field) else $error("mode field not updated"); // (R13)

    property p_sleep_can;
        (enter_sleep && (first_bus_control[1:0] == CAN_ON)) |=> (first_bus_control[1:0] == CAN_WAKE);
    endproperty
    a_sleep_can: assert property (p_sleep_can) else $error("transceiver left on in sleep"); // (R14)

    property p_fail_hold;
        (fail_output && (mode_now == MODE_SLEEP)) |=> fail_output;
    endproperty
    a_fail_hold: assert property (p_fail_hold) else $error("fail output dropped in sleep"); // (R15)

    property p_stop_lock;
        (exec && (mode_now == MODE_STOP) && (f_addr == A_FIRST_BUS) && !enter_sleep) |=> $stable(first_bus_control);
    endproperty
    a_stop_lock: assert property (p_stop_lock) else $error("configuration changed in stop"); // (R16)

    property p_ignore;
        (exec && (mode_now == MODE_SLEEP)) |=> $stable(watchdog_control);
    endproperty
    a_ignore: assert property (p_ignore) else $error("frame interpreted in sleep"); // (R22)

    property p_bank;
        (exec && wr_ok && (f_addr == A_BANK_FIRST)) |=> (swk_ff[$past(bank_sel)][0] == $past(f_data));
    endproperty
    a_bank: assert property (p_bank) else $error("banked write missed selected copy"); // (R17)

    property p_frame_summary;
        csn_fall |=> (tx_ff[7:0] == $past(summary_live)) && (spi_sdo == $past(summary_live[0]));
    endproperty
    a_frame_summary: assert property (p_frame_summary) else $error("response lacks fresh summary"); // (R24)

    c_ctrl_write: cover property (exec && wr_ok && !in_bank);
    c_status_clear: cover property (exec && interp && f_acc && (f_addr == STAT_ADDR[SI_DEVICE]));
    c_sleep_entry: cover property (enter_sleep && fail_output);
    c_bank_write: cover property (exec && wr_ok && in_bank && (bank_sel == 2'h3));

endmodule

// ---- include/basis_device_pkg.sv ----
// Constants, encodings and helpers shared by the register map of the basis device.
package basis_device_pkg;

    // Frame layout
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] FRAME_HALF = 5'h08;
    localparam logic [4:0] FRAME_CNT_MAX = 5'h1f;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Control register addresses
    localparam logic [6:0] A_MODE_SELECT = 7'h01;
    localparam logic [6:0] A_HW_CTRL_ZERO = 7'h02;
    localparam logic [6:0] A_WATCHDOG = 7'h03;
    localparam logic [6:0] A_FIRST_BUS = 7'h04;
    localparam logic [6:0] A_WAKE_A = 7'h05;
    localparam logic [6:0] A_WAKE_B = 7'h07;
    localparam logic [6:0] A_WAKE_PULL = 7'h08;
    localparam logic [6:0] A_SECOND_BUS = 7'h0a;
    localparam logic [6:0] A_FOURTH_BUS = 7'h0b;
    localparam logic [6:0] A_CTRL_FIRST = 7'h01;
    localparam logic [6:0] A_CTRL_LAST = 7'h3f;
    localparam logic [6:0] A_BANK_FIRST = 7'h20;
    localparam logic [6:0] A_BANK_LAST = 7'h37;
    localparam logic [5:0] A_OSC_PAIR = 6'h1d;

    // Status register addresses
    localparam logic [6:0] A_STAT_FIRST = 7'h40;
    localparam logic [6:0] A_STAT_LAST = 7'h7e;
    localparam logic [6:0] A_WAKE_LEVEL = 7'h48;

    localparam int STAT_N = 14;
    localparam int SI_SUP0 = 0;
    localparam int SI_SUP1 = 1;
    localparam int SI_THERMAL = 2;
    localparam int SI_DEVICE = 3;
    localparam int SI_BUS0 = 4;
    localparam int SI_BUS2 = 5;
    localparam int SI_WAKE0 = 6;
    localparam int SI_BUS3 = 7;
    localparam int SI_WAKE2 = 8;
    localparam int SI_SMPS = 9;
    localparam logic [6:0] STAT_ADDR [STAT_N] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46,
                                                  7'h47, 7'h49, 7'h4c, 7'h70, 7'h71, 7'h72, 7'h73};

    // Field positions
    localparam int MODE_LSB = 6;
    localparam int BANK_LSB = 0;
    localparam int CAN_FIELDS = 3;

    // Transceiver control encoding
    localparam logic [1:0] CAN_WAKE = 2'h1;
    localparam logic [1:0] CAN_ON = 2'h3;

    // Operating mode as reported by the mode controller
    localparam logic [2:0] MODE_INIT = 3'h0;
    localparam logic [2:0] MODE_NORMAL = 3'h1;
    localparam logic [2:0] MODE_STOP = 3'h2;
    localparam logic [2:0] MODE_SLEEP = 3'h3;
    localparam logic [2:0] MODE_RESTART = 3'h4;
    localparam logic [2:0] MODE_FAILSAFE = 3'h5;

    // Mode field values inside the mode select register
    localparam logic [1:0] MF_NORMAL = 2'h0;
    localparam logic [1:0] MF_SLEEP = 2'h1;
    localparam logic [1:0] MF_STOP = 2'h2;
    localparam logic [1:0] MF_RESTART = 2'h3;

    typedef enum logic {FRAME_IDLE, FRAME_SHIFT} frame_state_t;

    function automatic logic [1:0] mode_field(input logic [2:0] m);
        case (m)
            MODE_INIT, MODE_NORMAL: mode_field = MF_NORMAL;
            MODE_SLEEP: mode_field = MF_SLEEP;
            MODE_STOP: mode_field = MF_STOP;
            default: mode_field = MF_RESTART;
        endcase
    endfunction

endpackage

// ---- tb/spi_master_model.sv ----
// Serial master model sending LSB-first frames to the register map.
`timescale 1ns/1ps
module spi_master_model (
    output logic spi_csn_b,
    output logic spi_clk,
    output logic spi_sdi,
    input wire logic spi_sdo
);
    initial begin
        spi_csn_b = 1'b1;
        spi_clk = 1'b0;
        spi_sdi = 1'b0;
    end

    // Clock stands low outside frames; 125 ns period
    task automatic xfer(input logic [15:0] frame, input int nbits, output logic [15:0] resp);
        resp = 16'h0000;
        spi_csn_b = 1'b0;
        #100;
        for (int i = 0; i < nbits; i++) begin
            spi_sdi = frame[i];
            #62.5;
            spi_clk = 1'b1;
            resp[i] = spi_sdo;
            #62.5;
            spi_clk = 1'b0;
        end
        #62.5;
        spi_csn_b = 1'b1;
        // Released data line must not keep its last value
        spi_sdi = ~spi_sdi;
        #100;
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the serial register map.
`timescale 1ns/1ps
module tb_top;
    import basis_device_pkg::*;
    localparam int SBIT [10] = '{0, 0, 1, 2, 3, 4, 5, 4, 6, 7};
    localparam logic [2:0] DEAD [2] = '{MODE_RESTART, MODE_FAILSAFE};
    logic mclk = 1'b0;
    logic rst_b;
    logic spi_csn_b, spi_clk, spi_sdi, spi_sdo, spi_sdo_oe;
    logic [2:0] mode_now;
    logic [7:0] stat_ev [STAT_N];
    logic [7:0] wake_pin_level, osc_config_a, osc_config_b;
    logic fail_trigger, fail_release, fail_output;
    logic [7:0] status_summary, mode_select_control, watchdog_control;
    logic [7:0] first_bus_control, second_bus_group_control, fourth_bus_control;
    logic [7:0] r, s;
    logic [15:0] resp;
    int error_cnt = 0;
    int checked = 0;

    always #5 mclk = ~mclk;

    spi_master_model u_master (.spi_csn_b(spi_csn_b), .spi_clk(spi_clk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

    spi_register_map u_dut (
        .mclk(mclk), .rst_b(rst_b), .spi_csn_b(spi_csn_b), .spi_clk(spi_clk), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .mode_now(mode_now), .stat_event(stat_ev),
        .wake_pin_level(wake_pin_level), .osc_config_a(osc_config_a), .osc_config_b(osc_config_b),
        .fail_trigger(fail_trigger), .fail_release(fail_release), .fail_output(fail_output),
        .status_summary(status_summary), .mode_select_control(mode_select_control),
        .watchdog_control(watchdog_control), .first_bus_control(first_bus_control),
        .second_bus_group_control(second_bus_group_control), .fourth_bus_control(fourth_bus_control)
    );

    task automatic wrap_up();
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic frame(input logic [6:0] addr, input logic acc, input logic [7:0] data);
        u_master.xfer({data, acc, addr}, 16, resp);
        r = resp[15:8];
        s = resp[7:0];
    endtask

    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        frame(addr, 1'b1, data);
    endtask

    task automatic rd(input logic [6:0] addr, input logic [7:0] exp, input string what);
        frame(addr, 1'b0, 8'h00);
        chk8(what, exp, r);
    endtask

    task automatic pulse(input int idx, input logic [7:0] bits);
        @(negedge mclk) stat_ev[idx] = bits;
        @(negedge mclk) stat_ev[idx] = 8'h00;
        repeat (2) @(negedge mclk);
    endtask

    task automatic set_mode(input logic [2:0] m);
        @(negedge mclk) mode_now = m;
        repeat (3) @(negedge mclk);
    endtask

    task automatic fail_pin(input logic trig);
        @(negedge mclk) begin
            fail_trigger = trig;
            fail_release = ~trig;
        end
        @(negedge mclk) begin
            fail_trigger = 1'b0;
            fail_release = 1'b0;
        end
        repeat (2) @(negedge mclk);
    endtask

    initial begin
        #500us;
        error_cnt++;
        wrap_up();
    end

    initial begin
        rst_b = 1'b0;
        mode_now = MODE_NORMAL;
        foreach (stat_ev[i]) stat_ev[i] = 8'h00;
        wake_pin_level = 8'h5a;
        osc_config_a = 8'hc3;
        osc_config_b = 8'h3c;
        fail_trigger = 1'b0;
        fail_release = 1'b0;
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        repeat (3) @(negedge mclk);
        chk8("summary idle", 8'h00, status_summary);
        fork
            rd(A_WATCHDOG, 8'h00, "watchdog reset");
            begin
                repeat (20) @(negedge mclk);
                chk8("sdo enable busy", 8'h01, {7'h00, spi_sdo_oe});
            end
        join
        chk8("sdo enable idle", 8'h00, {7'h00, spi_sdo_oe});
        frame(A_WATCHDOG, 1'b1, 8'ha5);
        chk8("write response", 8'h00, r);
        chk8("watchdog port", 8'ha5, watchdog_control);
        rd(A_WATCHDOG, 8'ha5, "watchdog read");
        wr(A_CTRL_LAST, 8'h5a);
        rd(A_CTRL_LAST, 8'h5a, "last control");
        wr(7'h00, 8'h77);
        rd(7'h00, 8'h00, "unmapped");
        wr({A_OSC_PAIR, 1'b0}, 8'hff);
        rd({A_OSC_PAIR, 1'b0}, 8'hc3, "osc a");
        wr({A_OSC_PAIR, 1'b1}, 8'hff);
        rd({A_OSC_PAIR, 1'b1}, 8'h3c, "osc b");
        u_master.xfer({8'h11, 1'b1, A_WATCHDOG}, 15, resp);
        rd(A_WATCHDOG, 8'ha5, "short frame");
        // Each summarised register alone, then cleared
        for (int i = 0; i < 10; i++) begin
            pulse(i, 8'h81);
            chk8("summary set", 8'h01 << SBIT[i], status_summary);
            rd(STAT_ADDR[i], 8'h81, "status read");
            frame(STAT_ADDR[i], 1'b1, 8'h00);
            chk8("clear data", 8'h81, r);
            chk8("resp summary", 8'h01 << SBIT[i], s);
            rd(STAT_ADDR[i], 8'h00, "after clear");
            chk8("summary clear", 8'h00, s);
        end
        pulse(SI_SUP0, 8'h01);
        pulse(SI_SUP1, 8'h02);
        wr(STAT_ADDR[SI_SUP0], 8'h00);
        chk8("summary one left", 8'h01, status_summary);
        wr(STAT_ADDR[SI_SUP1], 8'h00);
        chk8("summary none", 8'h00, status_summary);
        rd(A_WAKE_LEVEL, 8'h5a, "wake level");
        wake_pin_level = 8'ha6;
        frame(A_WAKE_LEVEL, 1'b1, 8'h00);
        chk8("level clear", 8'ha6, r);
        chk8("level summary", 8'h00, s);
        rd(A_WAKE_LEVEL, 8'ha6, "level kept");
        wr(A_FOURTH_BUS, 8'h01);
        wr(A_BANK_FIRST, 8'h11);
        wr(A_FOURTH_BUS, 8'h03);
        wr(A_BANK_LAST, 8'h99);
        wr(A_BANK_FIRST, 8'h22);
        rd(A_BANK_FIRST, 8'h22, "bank 3");
        wr(A_FOURTH_BUS, 8'h01);
        rd(A_BANK_FIRST, 8'h11, "bank 1");
        rd(A_BANK_LAST, 8'h00, "bank 1 last");
        chk8("bank port", 8'h01, fourth_bus_control);
        pulse(12, 8'h44);
        rd(STAT_ADDR[12], 8'h44, "wake status ch2");
        wr(A_FIRST_BUS, 8'h03);
        wr(A_SECOND_BUS, 8'h3f);
        set_mode(MODE_STOP);
        chk8("mode stop", {MF_STOP, 6'h00}, mode_select_control & 8'hc0);
        wr(A_FIRST_BUS, 8'h00);
        chk8("stop config", 8'h03, first_bus_control);
        wr(A_WATCHDOG, 8'h33);
        chk8("stop watchdog", 8'h33, watchdog_control);
        fail_pin(1'b1);
        set_mode(MODE_SLEEP);
        chk8("sleep bus0", {6'h00, CAN_WAKE}, first_bus_control);
        chk8("sleep bus2", {2'h0, CAN_WAKE, CAN_WAKE, CAN_WAKE}, second_bus_group_control);
        chk8("mode sleep", {MF_SLEEP, 6'h00}, mode_select_control & 8'hc0);
        fail_pin(1'b0);
        chk8("fail kept", 8'h01, {7'h00, fail_output});
        wr(A_WATCHDOG, 8'h77);
        chk8("sleep write", 8'h33, watchdog_control);
        for (int k = 0; k < 2; k++) begin
            set_mode(DEAD[k]);
            chk8("mode dead", {MF_RESTART, 6'h00}, mode_select_control & 8'hc0);
            wr(A_WATCHDOG, 8'h77);
            chk8("dead write", 8'h33, watchdog_control);
        end
        set_mode(MODE_INIT);
        chk8("mode init", {MF_NORMAL, 6'h00}, mode_select_control & 8'hc0);
        wr(A_WATCHDOG, 8'h44);
        chk8("init write", 8'h44, watchdog_control);
        set_mode(MODE_NORMAL);
        chk8("mode normal", {MF_NORMAL, 6'h00}, mode_select_control & 8'hc0);
        fail_pin(1'b0);
        chk8("fail released", 8'h00, {7'h00, fail_output});
        wrap_up();
    end
endmodule
